/* ocd_map.svh */
`ifndef OCD_MAP_SVH
`define OCD_MAP_SVH
`define OCD_OP_PRODUCT 8'h42
`define OCD_GRP_IMM 4'hA
`define OCD_GRP_DIR 4'hB
`define OCD_GRP_EXT 4'hC
`define OCD_GRP_IX2 4'hD
`define OCD_GRP_IX1 4'hE
`define OCD_GRP_IX 4'hF
`define OCD_LO_COMPARE 4'h1
`define OCD_LO_SUBB 4'h2
`define OCD_LO_BIT 4'h5
`define OCD_LO_XOR 4'h8
`define OCD_LO_ADC 4'h9
`define OCD_BR_HI 8'h22
`define OCD_BR_LS 8'h23
`define OCD_BR_CC 8'h24
`define OCD_BR_CS 8'h25
`define OCD_BR_HCC 8'h28
`define OCD_BR_HCS 8'h29
`define OCD_BR_MC 8'h2C
`define OCD_BR_MS 8'h2D
`define OCD_BR_IL 8'h2E
`define OCD_BR_IH 8'h2F
`define OCD_CYC_PRODUCT 4'd11
`define OCD_CYC_BR 4'd3
`define OCD_CYC_IMM 4'd2
`define OCD_CYC_DIR 4'd3
`define OCD_CYC_EXT 4'd4
`define OCD_CYC_IX 4'd3
`define OCD_CYC_IX1 4'd4
`define OCD_CYC_IX2 4'd5
`define OCD_LEN_1 2'd1
`define OCD_LEN_2 2'd2
`define OCD_LEN_3 2'd3
`define OCD_RESET_PC 16'h0000
`define OCD_RESET_CCR 5'h08
`endif

/* ocd_pkg.sv */
package ocd_pkg;
  typedef enum logic [3:0] {
    OCD_OP_NONE, OCD_OP_MULT, OCD_OP_ADC, OCD_OP_SUBB, OCD_OP_XOR,
    OCD_OP_BIT, OCD_OP_COMPARE, OCD_OP_BRANCH
  } ocd_op_t;
  typedef enum logic [2:0] {
    OCD_AM_INH, OCD_AM_IMM, OCD_AM_DIR, OCD_AM_EXT, OCD_AM_IX, OCD_AM_IX1, OCD_AM_IX2,
    OCD_AM_REL
  } ocd_mode_t;
  typedef struct packed {
    ocd_op_t op;
    ocd_mode_t mode;
    logic [1:0] len;
    logic [3:0] cycles;
    logic valid;
  } ocd_dec_t;
  typedef struct packed {
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } ocd_ccr_t;
endpackage : ocd_pkg

/* ocd_decode.sv */
`timescale 1ns/100ps
`include "ocd_map.svh"
module ocd_decode
  import ocd_pkg::*;
(
  input wire logic [7:0] opcode,
  output ocd_dec_t dec
);
  always_comb
  begin
    dec = '{op: OCD_OP_NONE, mode: OCD_AM_INH, len: `OCD_LEN_1,
            cycles: `OCD_CYC_IMM, valid: 1'b0};
    if (opcode == `OCD_OP_PRODUCT)
    begin
      dec = '{op: OCD_OP_MULT, mode: OCD_AM_INH, len: `OCD_LEN_1,
              cycles: `OCD_CYC_PRODUCT, valid: 1'b1};
    end
    else if (opcode[7:4] == 4'h2 && (opcode[3:0] <= 4'h5 && opcode[3:0] >= 4'h2 ||
             opcode[3:0] >= 4'h8 && opcode[3:0] != 4'hA && opcode[3:0] != 4'hB))
    begin
      // always, never, zero and sign branches lie outside this block
      dec = '{op: OCD_OP_BRANCH, mode: OCD_AM_REL, len: `OCD_LEN_2,
              cycles: `OCD_CYC_BR, valid: 1'b1};
    end
    else if (opcode[7:4] >= `OCD_GRP_IMM)
    begin
      unique case (opcode[3:0])
        `OCD_LO_ADC: dec.op = OCD_OP_ADC;
        `OCD_LO_SUBB: dec.op = OCD_OP_SUBB;
        `OCD_LO_XOR: dec.op = OCD_OP_XOR;
        `OCD_LO_BIT: dec.op = OCD_OP_BIT;
        `OCD_LO_COMPARE: dec.op = OCD_OP_COMPARE;
        default: dec.op = OCD_OP_NONE;
      endcase
      dec.valid = (dec.op != OCD_OP_NONE);
      unique case (opcode[7:4])
        `OCD_GRP_IMM: dec = '{dec.op, OCD_AM_IMM, `OCD_LEN_2, `OCD_CYC_IMM, dec.valid};
        `OCD_GRP_DIR: dec = '{dec.op, OCD_AM_DIR, `OCD_LEN_2, `OCD_CYC_DIR, dec.valid};
        `OCD_GRP_EXT: dec = '{dec.op, OCD_AM_EXT, `OCD_LEN_3, `OCD_CYC_EXT, dec.valid};
        `OCD_GRP_IX: dec = '{dec.op, OCD_AM_IX, `OCD_LEN_1, `OCD_CYC_IX, dec.valid};
        `OCD_GRP_IX1: dec = '{dec.op, OCD_AM_IX1, `OCD_LEN_2, `OCD_CYC_IX1, dec.valid};
        `OCD_GRP_IX2: dec = '{dec.op, OCD_AM_IX2, `OCD_LEN_3, `OCD_CYC_IX2, dec.valid};
        default: dec.valid = 1'b0;
      endcase
    end
  end
endmodule : ocd_decode

/* ocd_core.sv */
`timescale 1ns/100ps
`include "ocd_map.svh"
// Behaviour
// - opcode 42 multiplies index by accumulator unsigned, one byte, 11 cycles
// - product high byte goes to index, low byte to accumulator
// - add-with-carry opcodes A9,B9,C9,F9,E9,D9 take 2,3,4,3,4,5 cycles
// - subtract-with-borrow opcodes A2..D2, lengths 2,2,3,1,2,3 bytes
// - exclusive-or opcodes A8,B8,C8,F8,E8,D8 over six modes
// - logical compare A5..D5 ands for flags only, accumulator kept
// - arithmetic compare A1..D1, 2 cycles immediate, 5 with 16-bit offset
// - 22 branches if higher, 23 if lower or same, 2 bytes 3 cycles
// - 24 branches on carry clear, 25 on carry set, aliases share them
// - 28 branches on half-carry clear, 29 on set, 2 bytes 3 cycles
// - 2C branches on mask clear, 2D on mask set, 2 bytes 3 cycles
// - 2E branches when interrupt pin sampled low
// - 2F branches when interrupt pin sampled high
// - add-with-carry sets half-carry on carry from bit 3 into bit 4
module ocd_core
  import ocd_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] opcode,
  input wire logic [15:0] operand,
  input wire logic [7:0] mem_data,
  input wire logic start,
  input wire logic irq_pin,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] idx_in,
  input wire logic [15:0] pc_in,
  input ocd_ccr_t ccr_in,
  input wire logic load,
  output logic busy,
  output logic done,
  output logic illegal,
  output logic [7:0] acc_q,
  output logic [7:0] idx_q,
  output logic [15:0] pc_q,
  output ocd_ccr_t ccr_q,
  output logic [1:0] len_q
);
  //////////////////////////////////////////////////////////////////////
  typedef enum logic {OCD_IDLE, OCD_EXEC} ocd_state_t;
  ocd_state_t state_q, state_d;
  ocd_dec_t dec;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] acc_d, idx_d;
  logic [15:0] pc_d;
  ocd_ccr_t ccr_d;
  logic [1:0] len_d;
  logic illegal_q, illegal_d;
  logic [8:0] sum;
  logic [4:0] nib;
  logic [15:0] prod;
  logic [15:0] next_pc;
  logic take;

  ocd_decode u_dec
  (
    .opcode(opcode),
    .dec(dec)
  );

  //////////////////////////////////////////////////////////////////////
  // branch condition
  always_comb
  begin
    unique case (opcode)
      `OCD_BR_HI: take = !(ccr_q.c | ccr_q.z);
      `OCD_BR_LS: take = ccr_q.c | ccr_q.z;
      `OCD_BR_CC: take = !ccr_q.c;
      `OCD_BR_CS: take = ccr_q.c;
      `OCD_BR_HCC: take = !ccr_q.h;
      `OCD_BR_HCS: take = ccr_q.h;
      `OCD_BR_MC: take = !ccr_q.i;
      `OCD_BR_MS: take = ccr_q.i;
      `OCD_BR_IL: take = !irq_pin;
      `OCD_BR_IH: take = irq_pin;
      default: take = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // results computed at start, held in registers; the counter only pads timing
  always_comb
  begin
    prod = 16'(acc_q) * 16'(idx_q);
    sum = 9'h000;
    nib = {1'b0, acc_q[3:0]} + {1'b0, mem_data[3:0]} + {4'h0, ccr_q.c};
    next_pc = pc_q + {14'h0000, dec.len};
    state_d = state_q;
    cnt_d = cnt_q;
    acc_d = acc_q;
    idx_d = idx_q;
    pc_d = pc_q;
    ccr_d = ccr_q;
    len_d = len_q;
    illegal_d = 1'b0;
    unique case (state_q)
      OCD_IDLE:
      begin
        if (load)
        begin
          acc_d = acc_in;
          idx_d = idx_in;
          pc_d = pc_in;
          ccr_d = ccr_in;
        end
        else if (start && !dec.valid)
        begin
          illegal_d = 1'b1;
        end
        else if (start)
        begin
          state_d = OCD_EXEC;
          cnt_d = dec.cycles - 4'd1;
          len_d = dec.len;
          pc_d = next_pc;
          unique case (dec.op)
            OCD_OP_MULT:
            begin
              idx_d = prod[15:8];
              acc_d = prod[7:0];
              ccr_d.h = 1'b0;
              ccr_d.c = 1'b0;
            end
            OCD_OP_ADC:
            begin
              sum = {1'b0, acc_q} + {1'b0, mem_data} + {8'h00, ccr_q.c};
              acc_d = sum[7:0];
              ccr_d.h = nib[4];
              ccr_d.c = sum[8];
              ccr_d.n = sum[7];
              ccr_d.z = (sum[7:0] == 8'h00);
            end
            OCD_OP_SUBB, OCD_OP_COMPARE:
            begin
              sum = {1'b0, acc_q} - {1'b0, mem_data}
                    - {8'h00, ccr_q.c & (dec.op == OCD_OP_SUBB)};
              if (dec.op == OCD_OP_SUBB)
              begin
                acc_d = sum[7:0];
              end
              ccr_d.c = sum[8];
              ccr_d.n = sum[7];
              ccr_d.z = (sum[7:0] == 8'h00);
            end
            OCD_OP_XOR:
            begin
              acc_d = acc_q ^ mem_data;
              ccr_d.n = acc_d[7];
              ccr_d.z = (acc_d == 8'h00);
            end
            OCD_OP_BIT:
            begin
              ccr_d.n = acc_q[7] & mem_data[7];
              ccr_d.z = ((acc_q & mem_data) == 8'h00);
            end
            OCD_OP_BRANCH:
            begin
              if (take)
              begin
                pc_d = next_pc + {{8{operand[7]}}, operand[7:0]};
              end
            end
            default:
            begin
              state_d = OCD_IDLE;
            end
          endcase
        end
      end
      OCD_EXEC:
      begin
        cnt_d = cnt_q - 4'd1;
        if (cnt_q == 4'd1)
        begin
          state_d = OCD_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_q <= OCD_IDLE;
      cnt_q <= 4'h0;
      acc_q <= 8'h00;
      idx_q <= 8'h00;
      pc_q <= `OCD_RESET_PC;
      ccr_q <= `OCD_RESET_CCR;
      len_q <= 2'h0;
      illegal_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      acc_q <= acc_d;
      idx_q <= idx_d;
      pc_q <= pc_d;
      ccr_q <= ccr_d;
      len_q <= len_d;
      illegal_q <= illegal_d;
    end
  end

  // done marks the last of the instruction's cycles
  assign busy = (state_q == OCD_EXEC);
  assign done = busy && (cnt_q == 4'd1);
  assign illegal = illegal_q;
endmodule : ocd_core

/* ocd_core_props.sv */
`timescale 1ns/100ps
module ocd_core_props
  import ocd_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] opcode,
  input wire logic [15:0] operand,
  input wire logic [7:0] mem_data,
  input wire logic start,
  input wire logic irq_pin,
  input wire logic load,
  input wire logic busy,
  input wire logic done,
  input wire logic [7:0] acc_q,
  input wire logic [7:0] idx_q,
  input wire logic [15:0] pc_q,
  input ocd_ccr_t ccr_q,
  input wire logic [1:0] len_q
);
  logic take;
  logic hc;
  logic cond;
  logic [15:0] tgt;
  assign take = start && !busy && !load;
  // carry in counts toward the nibble overflow
  assign hc = (5'(acc_q[3:0]) + 5'(mem_data[3:0]) + 5'(ccr_q.c)) > 5'h0F;
  assign cond = opcode[3] ? irq_pin : ccr_q.c;
  assign tgt = pc_q + 16'h0002 + {{8{operand[7]}}, operand[7:0]};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////
  sequence product_wait;
    ##1 (!done)[*8] ##1 done;
  endsequence
  sequence long_wait;
    (!done)[*3] ##1 done;
  endsequence
  product_timing_a: assert property (take && opcode == 8'h42 |=> product_wait)
    else $error("multiply timing wrong");
  product_result_a: assert property (take && opcode == 8'h42 |=>
    {idx_q, acc_q} == 16'($past(idx_q)) * 16'($past(acc_q))
    && !ccr_q.h && !ccr_q.c && ccr_q[3:1] == $past(ccr_q[3:1]))
    else $error("multiply result wrong");
  branch_time_a: assert property (take && opcode inside
    {[8'h22:8'h25], 8'h28, 8'h29, [8'h2C:8'h2F]} |=> !done ##1 done)
    else $error("branch timing wrong");
  cond_branch_a: assert property (take && opcode inside
    {8'h24, 8'h25, 8'h2E, 8'h2F} |=> pc_q == ($past(cond) == $past(opcode[0]) ?
    $past(tgt) : $past(pc_q) + 16'h0002))
    else $error("branch target wrong");
  half_carry_a: assert property (take && opcode == 8'hA9 |=> ccr_q.h == $past(hc))
    else $error("half carry wrong");
  bit_keeps_a: assert property (take && opcode[3:0] == 4'h5 && opcode[7:4] > 4'h9 |=>
    acc_q == $past(acc_q))
    else $error("bit test changed acc");
  xor_result_a: assert property (take && opcode[3:0] == 4'h8 && opcode[7:4] > 4'h9 |=>
    acc_q == ($past(acc_q) ^ $past(mem_data)))
    else $error("xor result wrong");
  index_len_a: assert property (take && opcode == 8'hF2 |=> len_q == 2'h1)
    else $error("indexed length wrong");
  long_index_a: assert property (take && opcode inside {8'hD9, 8'hD1} |=> long_wait)
    else $error("offset timing wrong");
endmodule : ocd_core_props
bind ocd_core ocd_core_props u_ocd_core_props (.*);

/* ocd_prog_mem.sv */
`timescale 1ns/100ps
module ocd_prog_mem
  import ocd_pkg::*;
(
  input wire logic [15:0] pc,
  output logic [7:0] opcode,
  output logic [15:0] operand,
  output logic [7:0] mem_data
);
  logic [7:0] mem [0:65535];
  // zero fill so a stray fetch shows a real byte, not unknowns
  initial foreach (mem[i]) mem[i] = 8'h00;
  assign opcode = mem[pc];
  assign operand = {mem[pc + 16'h0002], mem[pc + 16'h0001]};
  // page zero only: enough for the operand reads the bench makes
  assign mem_data = (opcode[7:4] == 4'hA) ? mem[pc + 16'h0001] : mem[{8'h00, operand[7:0]}];
endmodule : ocd_prog_mem

/* tb_cpu_opcode_decode_timing.sv */
`timescale 1ns/100ps
module tb_cpu_opcode_decode_timing;
  import ocd_pkg::*;
  logic clk = 1'b0, srst = 1'b1, start = 1'b0, load = 1'b0, irq_pin = 1'b0;
  logic [7:0] acc_in = 8'h00, idx_in = 8'h00, opcode, mem_data, acc_q, idx_q;
  logic [15:0] pc_in = 16'h0000, operand, pc_q;
  logic busy, done, illegal;
  logic [1:0] len_q;
  ocd_ccr_t ccr_in = 5'h00, ccr_q;
  int miscompares = 0, samples_checked = 0;
  always #5 clk = ~clk;
  ocd_core u_ocd_core (.clk(clk), .srst(srst), .opcode(opcode), .operand(operand),
    .mem_data(mem_data), .start(start), .irq_pin(irq_pin), .acc_in(acc_in), .idx_in(idx_in),
    .pc_in(pc_in), .ccr_in(ccr_in), .load(load), .busy(busy), .done(done), .illegal(illegal),
    .acc_q(acc_q), .idx_q(idx_q), .pc_q(pc_q), .ccr_q(ccr_q), .len_q(len_q));
  ocd_prog_mem u_ocd_prog_mem (.pc(pc_q), .opcode(opcode), .operand(operand),
    .mem_data(mem_data));
  ////////////////////////////////////////////////////////////
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick
  task automatic give_verdict;
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic prep(input logic [7:0] op, b1, a, x, input ocd_ccr_t c);
    u_ocd_prog_mem.mem[16'h0100] = op;
    u_ocd_prog_mem.mem[16'h0101] = b1;
    acc_in = a;
    idx_in = x;
    pc_in = 16'h0100;
    ccr_in = c;
    load = 1'b1;
    tick;
    load = 1'b0;
  endtask : prep
  // bounded wait on done; ends one cycle after done so the next start is legal
  task automatic run(input int cyc, input int hold = 1);
    int n;
    n = 0;
    start = 1'b1;
    repeat (hold)
    begin
      tick;
      n++;
    end
    start = 1'b0;
    while (done !== 1'b1 && n < 40)
    begin
      tick;
      n++;
    end
    if (n >= 40)
    begin
      miscompares++;
      give_verdict;
    end
    chk(16'(n + 1), 16'(cyc));
    tick;
  endtask : run
  ////////////////////////////////////////////////////////////
  task automatic t_product;
    prep(8'h42, 8'h00, 8'hFF, 8'hFF, 5'h1F);
    run(11);
    chk({idx_q, acc_q}, 16'hFE01);
    chk(16'(ccr_q), 16'h000E);
    chk(pc_q, 16'h0101);
  endtask : t_product
  // an opcode outside the block is refused; start held while busy is ignored
  task automatic t_refuse;
    prep(8'h21, 8'h00, 8'h12, 8'h34, 5'h00);
    start = 1'b1;
    tick;
    start = 1'b0;
    chk({busy, illegal}, 2'h1);
    chk({idx_q, acc_q}, 16'h3412);
    chk(pc_q, 16'h0100);
    tick;
    chk(illegal, 1'b0);
    prep(8'h42, 8'h00, 8'h07, 8'h03, 5'h00);
    run(11, 4);
    chk({idx_q, acc_q}, 16'h0015);
    chk(pc_q, 16'h0101);
  endtask : t_refuse
  task automatic t_regmem;
    logic [3:0] lo [5] = '{4'h9, 4'h2, 4'h8, 4'h5, 4'h1};
    logic [7:0] res [5] = '{8'h10, 8'h0E, 8'h0E, 8'h0F, 8'h0F};
    logic [3:0] hi [6] = '{4'hA, 4'hB, 4'hC, 4'hF, 4'hE, 4'hD};
    int cyc [6] = '{2, 3, 4, 3, 4, 5};
    logic [1:0] len [6] = '{2'h2, 2'h2, 2'h3, 2'h1, 2'h2, 2'h3};
    u_ocd_prog_mem.mem[16'h0001] = 8'h01;
    for (int i = 0; i < 5; i++)
      for (int m = 0; m < 6; m++)
      begin
        prep({hi[m], lo[i]}, 8'h01, 8'h0F, 8'h00, 5'h00);
        run(cyc[m]);
        chk(acc_q, res[i]);
        chk(len_q, len[m]);
        if (i == 0)
          chk(ccr_q.h, 1'b1);
      end
  endtask : t_regmem
  task automatic t_branch;
    logic [7:0] ops [10] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h28,
      8'h29, 8'h2C, 8'h2D, 8'h2E, 8'h2F};
    for (int k = 0; k < 20; k++)
    begin
      irq_pin = k[0];
      prep(ops[k / 2], 8'hF0, 8'h00, 8'h00, {5{k[0]}});
      run(3);
      chk(pc_q, (k[0] == ops[k / 2][0]) ? 16'h00F2 : 16'h0102);
    end
  endtask : t_branch
  initial
  begin
    repeat (12) tick;
    srst = 1'b0;
    chk({idx_q, acc_q}, 16'h0000);
    chk(16'(ccr_q), 16'h0008);
    chk({busy, done, illegal}, 3'h0);
    t_product;
    t_regmem;
    t_branch;
    t_refuse;
    give_verdict;
  end
endmodule : tb_cpu_opcode_decode_timing
